// ==== rsm_pkg.sv ====
// Purpose: Shared constants and carriers for the reset strap mode capture.
// Assumes: Registers sit on classic Wishbone, one 32-bit word each.
// Notes:   Byte addresses; reserved register bits read as zero.
package rsm_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL     = 4'h0;
   localparam logic [3:0] REG_STAT     = 4'h4;

   localparam int unsigned CTRL_TURN_LSB = 0;
   localparam int unsigned CTRL_DIR_LSB  = 2;
   localparam int unsigned CTRL_OUT_LSB  = 4;
   localparam int unsigned CTRL_WIDTH    = 6;

   localparam logic [1:0] TURN_RST     = 2'h3;
   localparam logic [1:0] DIR_RST      = 2'h0;
   localparam logic [1:0] OUT_RST      = 2'h0;

   localparam int unsigned STAT_BOOT_LSB = 0;
   localparam int unsigned STAT_HOLD     = 2;
   localparam int unsigned STAT_MSB      = 3;
   localparam int unsigned STAT_TRACE    = 4;
   localparam int unsigned STAT_TRI      = 5;
   localparam int unsigned STAT_BR_LSB   = 6;

   // -----------------------------------------------------------------
   // Strap vector layout in the synchroniser
   // -----------------------------------------------------------------
   localparam int unsigned STRAP_W      = 9;
   localparam int unsigned STRAP_IRQ0   = 0;
   localparam int unsigned STRAP_IRQ3   = 1;
   localparam int unsigned STRAP_ADDR2  = 2;
   localparam int unsigned STRAP_ADDR3  = 3;
   localparam int unsigned STRAP_SP_LSB = 4;

   localparam logic [1:0] BOOT_32      = 2'h0;
   localparam logic [1:0] BOOT_16      = 2'h1;
   localparam logic [1:0] BOOT_8       = 2'h2;

   typedef struct packed {
      logic [1:0] boot_width;
      logic       long_latch_hold;
      logic       msb_first_byte_order;
      logic       fetch_trace_output;
      logic       tristate_test;
   } rsm_modes_t;

   localparam rsm_modes_t MODES_RST = '{BOOT_32, 1'b0, 1'b1, 1'b0, 1'b0};

   // One bus access from the cycle engine
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [3:0] addr;
      logic [1:0] half_word_lane_enable;
      logic       cacheable;
      logic       last;
   } rsm_acc_t;

endpackage

// ==== rsm_sync.sv ====
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes:   No reset, so straps keep flowing while nrst is low.
`timescale 1ns/100ps
module rsm_sync #(
   parameter int unsigned W = 1
) (
   // Clock
   input  wire logic         clk,
   // Data
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      meta_r <= din;
      dout   <= meta_r;
   end
endmodule

// ==== rsm_turn.sv ====
// Purpose: Bus turnaround gap counter.
// Assumes: take is a one-cycle strobe for an accepted access.
// Notes:   block is combinational, used inside the top only.
`timescale 1ns/100ps
module rsm_turn (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Access view
   input  wire logic       valid,
   input  wire logic       wr,
   input  wire logic       take,
   input  wire logic [1:0] gap,
   // Gate
   output logic            block
);
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic       dir_r;
   logic       seen_r;
   logic       paid_r;
   wire        change = valid && seen_r && (wr != dir_r);
   wire        load   = change && !paid_r && (gap != 2'h0);

   // The load cycle is the first idle cycle, so the count starts one short
   assign block   = load || (cnt_r != 2'h0);
   assign cnt_nxt = load ? gap - 2'h1 :
                    (cnt_r != 2'h0) ? cnt_r - 2'h1 : cnt_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r  <= 2'h0;
         dir_r  <= 1'b0;
         seen_r <= 1'b0;
         paid_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (take) begin
            dir_r  <= wr;
            seen_r <= 1'b1;
            paid_r <= 1'b0;
         end else if (load) begin
            paid_r <= 1'b1;
         end
      end
   end
endmodule

// ==== rsm_top.sv ====
// Purpose: Captures reset straps, applies modes, drives spare pins.
// Assumes: clk runs at 10 MHz and keeps toggling while nrst is low.
// Notes:   Straps are caught at the first edge after reset release.
`timescale 1ns/100ps
module rsm_top (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                nrst,
   // Wishbone slave
   input  wire logic                wb_cyc,
   input  wire logic                wb_stb,
   input  wire logic                wb_we,
   input  wire logic [3:0]          wb_adr,
   input  wire logic [3:0]          wb_sel,
   input  wire logic [31:0]         wb_wdat,
   output logic      [31:0]         wb_rdat,
   output logic                     wb_ack,
   // Strap inputs
   input  wire logic                sync_irq_line0,
   input  wire logic                irq_line3,
   // Low address pins 3:2, strap then output
   input  wire logic [1:0]          addr_pin_in,
   output logic      [1:0]          addr_pin_out,
   output logic      [1:0]          addr_pin_oe,
   // Spare pins
   input  wire logic [4:0]          spare_pin_in,
   output logic      [3:0]          spare_pin_out,
   output logic      [3:0]          spare_pin_oe,
   // Branch flag pins 3:2
   input  wire logic [1:0]          branch_flag_input,
   output logic      [1:0]          sync_branch_flag_pin_out,
   output logic      [1:0]          sync_branch_flag_pin_oe,
   // Access from the cycle engine
   input  wire rsm_pkg::rsm_acc_t   acc,
   output logic                     acc_done,
   output logic                     cacheable_out,
   output logic                     last_out,
   // Captured modes
   output rsm_pkg::rsm_modes_t      modes
);

   // ----------------------------------------------------------------
   // Strap synchronisers
   // ----------------------------------------------------------------
   logic [rsm_pkg::STRAP_W-1:0] strap_s;
   logic [1:0]                  br_s;

   rsm_sync #(.W(rsm_pkg::STRAP_W)) u_strap_sync (
      .clk  (clk),
      .din  ({spare_pin_in, addr_pin_in, irq_line3, sync_irq_line0}),
      .dout (strap_s)
   );

   rsm_sync #(.W(2)) u_br_sync (
      .clk  (clk),
      .din  (branch_flag_input),
      .dout (br_s)
   );

   // ----------------------------------------------------------------
   // Strap decode
   // ----------------------------------------------------------------
   logic                 started_r;
   rsm_pkg::rsm_modes_t  modes_r;
   rsm_pkg::rsm_modes_t  modes_nxt;
   wire                  cap     = !started_r;
   wire                  a2      = strap_s[rsm_pkg::STRAP_ADDR2];
   wire                  a3      = strap_s[rsm_pkg::STRAP_ADDR3];
   wire [4:0]            sp      = strap_s[rsm_pkg::STRAP_SP_LSB +: 5];
   // Byte port wins when both boot straps are pulled low
   wire [1:0]            boot_sel = !a2 ? rsm_pkg::BOOT_8 :
                                    !a3 ? rsm_pkg::BOOT_16 :
                                          rsm_pkg::BOOT_32;

   assign modes_nxt.boot_width           = boot_sel;
   assign modes_nxt.long_latch_hold      = !sp[0];
   assign modes_nxt.msb_first_byte_order =
      strap_s[rsm_pkg::STRAP_IRQ0];
   assign modes_nxt.fetch_trace_output   =
      !strap_s[rsm_pkg::STRAP_IRQ3];
   assign modes_nxt.tristate_test        = !sp[4];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         started_r <= 1'b0;
         modes_r   <= rsm_pkg::MODES_RST;
      end else begin
         started_r <= 1'b1;
         if (cap) begin
            modes_r <= modes_nxt;
         end
      end
   end

   assign modes = modes_r;

   // ----------------------------------------------------------------
   // Control register and Wishbone slave
   // ----------------------------------------------------------------
   logic [rsm_pkg::CTRL_WIDTH-1:0] ctrl_r;
   logic                           ack_r;
   logic [31:0]                    rdat_r;
   wire  req      = wb_cyc && wb_stb && !ack_r;
   wire  hit_ctrl = (wb_adr == rsm_pkg::REG_CTRL);
   wire  hit_stat = (wb_adr == rsm_pkg::REG_STAT);
   // Writes land on the edge that sees ack high, the same edge at which
   // the master takes the answer and releases the request
   wire  ctrl_we  = wb_cyc && wb_stb && ack_r && wb_we && hit_ctrl &&
                    wb_sel[0];
   wire [1:0] turn_gap = ctrl_r[rsm_pkg::CTRL_TURN_LSB +: 2];
   wire [1:0] br_dir   = ctrl_r[rsm_pkg::CTRL_DIR_LSB +: 2];
   wire [1:0] br_val   = ctrl_r[rsm_pkg::CTRL_OUT_LSB +: 2];

   wire [31:0] stat_word = {24'h0, br_s,
                            modes_r.tristate_test,
                            modes_r.fetch_trace_output,
                            modes_r.msb_first_byte_order,
                            modes_r.long_latch_hold,
                            modes_r.boot_width};
   // Unmapped words answer with zero and drop writes
   wire [31:0] rd_mux = hit_ctrl ? {26'h0, ctrl_r} :
                        hit_stat ? stat_word : 32'h0;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r <= {rsm_pkg::OUT_RST, rsm_pkg::DIR_RST,
                    rsm_pkg::TURN_RST};
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
      end else begin
         ack_r <= req;
         if (req) begin
            rdat_r <= rd_mux;
         end
         if (ctrl_we) begin
            ctrl_r <= wb_wdat[rsm_pkg::CTRL_WIDTH-1:0];
         end
      end
   end

   assign wb_ack  = ack_r;
   assign wb_rdat = rdat_r;

   // ----------------------------------------------------------------
   // Access path and turnaround
   // ----------------------------------------------------------------
   logic       block;
   logic       done_r;
   logic [3:0] spare_out_r;
   logic [1:0] addr_out_r;
   logic       cache_r;
   logic       last_r;
   wire        take = acc.valid && !done_r && !block;

   rsm_turn u_turn (
      .clk   (clk),
      .nrst  (nrst),
      .valid (acc.valid && !done_r),
      .wr    (acc.wr),
      .take  (take),
      .gap   (turn_gap),
      .block (block)
   );

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_r      <= 1'b0;
         spare_out_r <= 4'h0;
         addr_out_r  <= 2'h0;
         cache_r     <= 1'b0;
         last_r      <= 1'b0;
      end else begin
         done_r <= take;
         if (take) begin
            spare_out_r <= {acc.half_word_lane_enable,
                            acc.addr[1:0]};
            addr_out_r  <= acc.addr[3:2];
            cache_r     <= acc.cacheable;
            last_r      <= acc.last;
         end
      end
   end

   assign acc_done      = done_r;
   assign spare_pin_out = spare_out_r;
   assign addr_pin_out  = addr_out_r;
   assign cacheable_out = cache_r;
   assign last_out      = last_r;

   // ----------------------------------------------------------------
   // Pin drive enables
   // ----------------------------------------------------------------
   // Pins stay released through reset so board straps are never fought
   logic       drive_r;
   logic [1:0] br_oe_r;
   logic [1:0] br_out_r;
   wire        drive_nxt = started_r && !modes_r.tristate_test;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drive_r  <= 1'b0;
         br_oe_r  <= 2'h0;
         br_out_r <= 2'h0;
      end else begin
         drive_r  <= drive_nxt;
         br_oe_r  <= drive_nxt ? br_dir : 2'h0;
         br_out_r <= br_val;
      end
   end

   assign spare_pin_oe             = {4{drive_r}};
   assign addr_pin_oe              = {2{drive_r}};
   assign sync_branch_flag_pin_oe  = br_oe_r;
   assign sync_branch_flag_pin_out = br_out_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Release lands on a clock edge, so capture checks also need nrst
   wire cap_live = cap && nrst;

   boot_wide_a: assert property (cap_live && a2 && a3 |=>
      modes_r.boot_width == rsm_pkg::BOOT_32)
      else $error("boot width not 32 with both straps high");
   boot_half_a: assert property (cap_live && a2 && !a3 |=>
      modes_r.boot_width == rsm_pkg::BOOT_16)
      else $error("boot width not 16");
   boot_byte_a: assert property (cap_live && !a2 |=>
      modes_r.boot_width == rsm_pkg::BOOT_8)
      else $error("boot width not 8");
   hold_off_a: assert property (cap_live && sp[0] |=>
      !modes_r.long_latch_hold ##1 !modes_r.long_latch_hold)
      else $error("long hold enabled with spare pin zero high");
   byte_order_a: assert property (cap_live |=>
      modes_r.msb_first_byte_order ==
      $past(strap_s[rsm_pkg::STRAP_IRQ0]))
      else $error("byte order differs from irq zero strap");
   modes_hold_a: assert property (started_r |=>
      $stable(modes_r))
      else $error("captured modes changed after reset");
   trace_sel_a: assert property (cap_live |=>
      modes_r.fetch_trace_output ==
      !$past(strap_s[rsm_pkg::STRAP_IRQ3]))
      else $error("trace mode differs from irq three strap");
   tri_release_a: assert property (started_r &&
      modes_r.tristate_test |=> spare_pin_oe == 4'h0 &&
      sync_branch_flag_pin_oe == 2'h0)
      else $error("pins driven in three-state test mode");
   pin_drive_a: assert property (started_r &&
      !modes_r.tristate_test |=> spare_pin_oe == 4'hf &&
      addr_pin_oe == 2'h3)
      else $error("spare or address pins not driven after reset");
   lane_out_a: assert property (take |=> acc_done &&
      spare_pin_out == {$past(acc.half_word_lane_enable),
                        $past(acc.addr[1:0])})
      else $error("lane enables or low address wrong");
   addr_out_a: assert property (take |=>
      addr_pin_out == $past(acc.addr[3:2]))
      else $error("upper address pins wrong");
   lane_keep_a: assert property (!take |=>
      $stable(spare_pin_out) && $stable(addr_pin_out))
      else $error("pin outputs changed without an access");
   cache_out_a: assert property (take |=>
      cacheable_out == $past(acc.cacheable) &&
      last_out == $past(acc.last))
      else $error("cacheable or last flag wrong");
   cache_keep_a: assert property (!take |=>
      $stable(cacheable_out) && $stable(last_out))
      else $error("cacheable or last flag changed without an access");
   br_input_a: assert property (!started_r |=>
      sync_branch_flag_pin_oe == 2'h0)
      else $error("branch flag pins driven out of reset");
   br_dir_a: assert property (started_r &&
      !modes_r.tristate_test |=>
      sync_branch_flag_pin_oe == $past(br_dir) &&
      sync_branch_flag_pin_out == $past(br_val))
      else $error("branch flag pin drive differs from control");
   stat_read_a: assert property (req && !wb_we && hit_stat |=>
      wb_rdat[rsm_pkg::STAT_BR_LSB +: 2] == $past(br_s))
      else $error("branch flag inputs not readable in status");
   turn_gap_a: assert property ($rose(block) &&
      turn_gap == 2'h3 |-> !take [*3] ##1 take)
      else $error("turnaround gap not three idle cycles");
   turn_one_a: assert property ($rose(block) &&
      turn_gap == 2'h1 |-> !take ##1 take)
      else $error("turnaround gap not one idle cycle");
   turn_rst_a: assert property (cap_live |->
      turn_gap == rsm_pkg::TURN_RST)
      else $error("turnaround field not at slowest after reset");
   ctrl_load_a: assert property (ctrl_we |=>
      ctrl_r == $past(wb_wdat[rsm_pkg::CTRL_WIDTH-1:0]))
      else $error("control write did not land");
   ctrl_keep_a: assert property (!ctrl_we |=>
      $stable(ctrl_r))
      else $error("control field changed without a write");
   ack_once_a: assert property (wb_ack |=> !wb_ack)
      else $error("bus acknowledge longer than one cycle");
   done_once_a: assert property (acc_done |=> !acc_done)
      else $error("access done longer than one cycle");

   boot_byte_c:  cover property (cap && !a2);
   ctrl_write_c: cover property (ctrl_we);
   turn_wait_c:  cover property (block ##[1:4] take);
   turn_one_c:   cover property ($rose(block) && turn_gap == 2'h1);
   trace_mode_c: cover property (started_r && modes_r.fetch_trace_output);

endmodule

// ==== rsm_board.sv ====
// Purpose: Board model: strap resistors, switches, reset-time buffer.
// Assumes: strap bits: [0] irq0, [1] irq3, [3:2] addr 3:2, [8:4] spare.
// Notes:   Lines let go after reset fall back to their pull-ups.
`timescale 1ns/100ps
module rsm_brd (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // Switch settings and design drive
   input  wire logic [8:0] strap,
   input  wire logic [1:0] addr_out,
   input  wire logic [1:0] addr_oe,
   input  wire logic [3:0] spare_out,
   input  wire logic [3:0] spare_oe,
   // Resolved pin levels
   output logic            irq0,
   output logic            irq3,
   output logic      [1:0] addr_pin,
   output logic      [4:0] spare_pin
);
   logic drv_r;
   // Buffer drives all through reset, lets go one edge after release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         drv_r <= 1'b1;
      else
         drv_r <= 1'b0;
   end
   // Irq lines carry other traffic later, so they must not be re-read
   assign irq0 = drv_r ? strap[0] : ~strap[0];
   assign irq3 = drv_r ? strap[1] : ~strap[1];
   assign addr_pin = drv_r ? strap[3:2] : (addr_oe & addr_out) | ~addr_oe;
   assign spare_pin[3:0] = drv_r ? strap[7:4]
                                 : (spare_oe & spare_out) | ~spare_oe;
   assign spare_pin[4] = drv_r ? strap[8] : 1'b1;
endmodule

// ==== rsm_top_test.sv ====
// Purpose: Self-checking bench for the reset strap mode capture.
// Assumes: Board model presents straps in reset, pull-ups after, irq lines inverted.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/100ps
module rsm_top_test;
   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [3:0]  wb_adr = 4'h0;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic [8:0]  strap = 9'h1ff;
   logic        irq0;
   logic        irq3;
   logic [1:0]  addr_pin;
   logic [1:0]  addr_out;
   logic [1:0]  addr_oe;
   logic [4:0]  spare_pin;
   logic [3:0]  spare_out;
   logic [3:0]  spare_oe;
   logic [1:0]  br_in = 2'h2;
   logic [1:0]  br_out;
   logic [1:0]  br_oe;
   logic        acc_done;
   logic        cach;
   logic        last;
   int          err_count = 0;
   int          compares = 0;
   rsm_pkg::rsm_acc_t   acc = '0;
   rsm_pkg::rsm_modes_t modes;

   always #50 clk = ~clk;

   rsm_brd board (.clk(clk), .nrst(nrst), .strap(strap),
      .addr_out(addr_out), .addr_oe(addr_oe), .spare_out(spare_out),
      .spare_oe(spare_oe), .irq0(irq0), .irq3(irq3),
      .addr_pin(addr_pin), .spare_pin(spare_pin));
   rsm_top dut (.clk(clk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat),
      .wb_rdat(wb_rdat), .wb_ack(wb_ack), .sync_irq_line0(irq0),
      .irq_line3(irq3), .addr_pin_in(addr_pin), .addr_pin_out(addr_out),
      .addr_pin_oe(addr_oe), .spare_pin_in(spare_pin),
      .spare_pin_out(spare_out), .spare_pin_oe(spare_oe),
      .branch_flag_input(br_in), .sync_branch_flag_pin_out(br_out),
      .sync_branch_flag_pin_oe(br_oe), .acc(acc), .acc_done(acc_done),
      .cacheable_out(cach), .last_out(last), .modes(modes));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("mismatches=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [3:0] sel, input logic [31:0] wd,
                     output logic [31:0] rd);
      int n = 0;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= sel;
      wb_wdat <= wd;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 20)
         chk(32'h0, 32'h1);
   endtask

   // Every reset, warm or not, lasts the full six cycles
   task automatic rst(input logic [8:0] v);
      @(posedge clk);
      nrst <= 1'b0;
      strap <= v;
      repeat (6) @(posedge clk);
      chk(32'(modes), 32'(rsm_pkg::MODES_RST));
      chk(32'({spare_oe, addr_oe, br_oe}), 32'h0);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   // Latency counted in edges from raising valid to seeing done
   task automatic acc_go(input logic wr, input logic [3:0] a,
                         input logic [1:0] ln, input int gap);
      int n = 0;
      @(posedge clk);
      acc <= '{1'b1, wr, a, ln, a[0], a[1]};
      do begin
         @(posedge clk);
         n++;
      end while (acc_done !== 1'b1 && n < 20);
      acc.valid <= 1'b0;
      chk(32'(n), 32'(gap + 2));
      chk(32'({addr_out, spare_out, cach, last}),
          32'({a[3:2], ln, a[1:0], a[0], a[1]}));
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_straps;
      // Spare 3:1 always high, as reserved straps must be
      logic [8:0] tab [4] = '{9'h1ff, 9'h1e4, 9'h0fb, 9'h1f3};
      logic [31:0] rd;
      rsm_pkg::rsm_modes_t ex;
      foreach (tab[i]) begin
         rst(tab[i]);
         ex.boot_width = !tab[i][2] ? rsm_pkg::BOOT_8 :
                         !tab[i][3] ? rsm_pkg::BOOT_16 : rsm_pkg::BOOT_32;
         ex.long_latch_hold = ~tab[i][4];
         ex.msb_first_byte_order = tab[i][0];
         ex.fetch_trace_output = ~tab[i][1];
         ex.tristate_test = ~tab[i][8];
         chk(32'(modes), 32'(ex));
         wb(1'b0, rsm_pkg::REG_STAT, 4'hf, 32'h0, rd);
         chk(rd, {24'h0, br_in, ex.tristate_test, ex.fetch_trace_output,
             ex.msb_first_byte_order, ex.long_latch_hold,
             ex.boot_width});
         chk(32'({spare_oe, addr_oe}),
             ex.tristate_test ? 32'h0 : 32'h3f);
      end
      $display("strap capture test done");
   endtask

   task automatic t_access;
      logic [31:0] rd;
      acc_go(1'b0, 4'h5, 2'h2, 0);
      acc_go(1'b0, 4'ha, 2'h1, 0);
      acc_go(1'b1, 4'hf, 2'h3, 3);
      wb(1'b1, rsm_pkg::REG_CTRL, 4'h1, 32'h0, rd);
      acc_go(1'b0, 4'h2, 2'h0, 0);
      acc_go(1'b1, 4'h1, 2'h1, 0);
      wb(1'b1, rsm_pkg::REG_CTRL, 4'h1, 32'h1, rd);
      acc_go(1'b0, 4'h6, 2'h2, 1);
      $display("access test done");
   endtask

   task automatic t_regs;
      logic [31:0] rd;
      rst(9'h1ff);
      wb(1'b0, rsm_pkg::REG_CTRL, 4'hf, 32'h0, rd);
      chk(rd, 32'h3);
      wb(1'b1, rsm_pkg::REG_CTRL, 4'he, 32'h3c, rd);
      wb(1'b1, 4'h8, 4'hf, 32'hffff_ffff, rd);
      wb(1'b0, 4'h8, 4'hf, 32'h0, rd);
      chk(rd, 32'h0);
      wb(1'b0, rsm_pkg::REG_CTRL, 4'hf, 32'h0, rd);
      chk(rd, 32'h3);
      wb(1'b1, rsm_pkg::REG_CTRL, 4'h1, 32'hffff_ff2c, rd);
      wb(1'b1, rsm_pkg::REG_STAT, 4'hf, 32'h0, rd);
      wb(1'b0, rsm_pkg::REG_CTRL, 4'hf, 32'h0, rd);
      chk(rd, 32'h2c);
      chk(32'({br_oe, br_out}), 32'he);
      $display("register test done");
   endtask

   initial begin
      t_straps();
      t_access();
      t_regs();
      end_sim();
   end

   initial begin
      repeat (3000) @(posedge clk);
      err_count++;
      end_sim();
   end
endmodule
